// ===== rtl/protected_register_write_gate.sv
// Write gate between core, debug port and protected peripheral frames
//
// How it works
// - Two back-to-back writes into frame one cost one stall cycle.
// - Frame one takes both 16-bit and 32-bit accesses.
// - Frame two supports only 16-bit accesses.
// - 32-bit accesses to frame two are not honoured and never reach the frame.
// - The unlock flag is a bit of core status register one showing protection state.
// - Reset clears the unlock flag so protection is active at once.
// - With the flag at 0, core writes to protected registers are discarded.
// - Core reads and debug reads and writes pass, except 32-bit accesses to frame two.
// - With the flag at 1, core writes to protected registers pass freely.
// - The protect instruction clears the unlock flag.
// - Debug-port accesses override the unlock flag.
// - Emulation, flash, security, vector table, system control and pin-mux are protected.
// - Comparator and modulator ranges are protected per register or per bit.
`timescale 1ns/100ps
module protected_register_write_gate #(
    parameter logic [255:0] CMP_REG_MASK = {256{1'b1}},
    parameter logic [255:0] PWM_REG_MASK = {256{1'b1}},
    parameter logic [31:0]  CMP_BIT_MASK = 32'hffffffff,
    parameter logic [31:0]  PWM_BIT_MASK = 32'hffffffff
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Instruction strobes from the core
    input  wire logic        unlock_instruction,
    input  wire logic        protect_instruction,
    input  wire logic        protect_instruction_alias,
    // Requester side
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_wide,
    input  wire logic        req_debug,
    input  wire logic [21:0] req_addr,
    input  wire logic [31:0] req_wdata,
    output logic             req_ready,
    output logic             req_done,
    output logic [31:0]      req_rdata,
    // Peripheral side
    output logic             per_valid,
    output logic             per_write,
    output logic             per_wide,
    output logic [21:0]      per_addr,
    output logic [31:0]      per_wdata,
    output logic [31:0]      per_wmask,
    input  wire logic [31:0] per_rdata,
    // Status
    output logic [15:0]      core_status_register_one,
    output logic             write_unlock_flag
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic        in_frame1;
    logic        in_frame2;
    logic        prot_any;
    logic [31:0] prot_bits;
    logic        last_f1_write;
    logic        stall;
    logic        take;
    logic        illegal;
    logic        locked;
    logic [31:0] next_wmask;
    logic        next_unlock;
    logic        drop;
    logic        next_fwd;

    protect_decode #(
        .CMP_REG_MASK (CMP_REG_MASK),
        .PWM_REG_MASK (PWM_REG_MASK),
        .CMP_BIT_MASK (CMP_BIT_MASK),
        .PWM_BIT_MASK (PWM_BIT_MASK)
    ) u_decode (
        .addr      (req_addr),
        .in_frame1 (in_frame1),
        .in_frame2 (in_frame2),
        .prot_any  (prot_any),
        .prot_bits (prot_bits)
    );

    // ------------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------------
    // stall second write
    assign stall   = req_valid && req_write && in_frame1 && last_f1_write;
    assign take    = clk_en && req_valid && !stall;
    assign illegal = in_frame2 && req_wide;
    assign locked  = !write_unlock_flag && !req_debug;

    // Lanes the write may touch; protected lanes cleared while locked
    always_comb begin
        next_wmask = req_wide ? 32'hffffffff : 32'h0000ffff;
        if (locked) begin
            next_wmask = next_wmask & ~prot_bits;
        end
    end

    // ------------------------------------------------------------------
    // Unlock flag
    // ------------------------------------------------------------------
    // Clear wins over set, so a stray unlock cannot beat a protect
    always_comb begin
        next_unlock = write_unlock_flag;
        if (protect_instruction || protect_instruction_alias) begin
            next_unlock = 1'b0;
        end else if (unlock_instruction) begin
            next_unlock = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            write_unlock_flag <= 1'b0;
        end else if (clk_en) begin
            write_unlock_flag <= next_unlock;
        end
    end

    // ------------------------------------------------------------------
    // Status register one
    // ------------------------------------------------------------------
    // flag mirrored in status
    // Own flop fed from the same next value, so the bit never lags the flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            core_status_register_one <= write_gate_pkg::STAT1_RESET;
        end else if (clk_en) begin
            core_status_register_one <= write_gate_pkg::STAT1_RESET;
            core_status_register_one[write_gate_pkg::STAT1_UNLOCK_BIT] <= next_unlock;
        end
    end

    // ------------------------------------------------------------------
    // Back-to-back tracker for frame one writes
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_f1_write <= 1'b0;
        end else if (clk_en) begin
            last_f1_write <= take && req_write && in_frame1;
        end
    end

    // Ready drops for the one cycle after each taken frame-one write, whether or not a write then stalls
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b1;
        end else if (clk_en) begin
            req_ready <= !(req_valid && req_write && in_frame1 && !stall);
        end
    end

    // ------------------------------------------------------------------
    // Forwarding to the peripheral frames
    // ------------------------------------------------------------------
    // Locked write whose lanes are all protected is swallowed here
    assign drop     = req_write && locked && ~|next_wmask && prot_any;
    assign next_fwd = take && !illegal && !drop;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            per_valid <= 1'b0;
            req_done  <= 1'b0;
        end else if (clk_en) begin
            req_done  <= take;
            per_valid <= next_fwd;
        end
    end

    // Copies load only on a taken request, so they stay put while idle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            per_write <= 1'b0;
            per_wide  <= 1'b0;
            per_addr  <= 22'h000000;
        end else if (take) begin
            per_write <= req_write;
            per_wide  <= req_wide;
            per_addr  <= req_addr;
        end
    end

    // Write lanes; a read carries no lane enables
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            per_wdata <= 32'h00000000;
            per_wmask <= 32'h00000000;
        end else if (take) begin
            per_wdata <= req_wdata;
            per_wmask <= req_write ? next_wmask : 32'h00000000;
        end
    end

    // Read data; wide frame two reads give zero rather than garbage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_rdata <= 32'h00000000;
        end else if (clk_en) begin
            req_rdata <= per_valid ? per_rdata : 32'h00000000;
        end
    end

endmodule // protected_register_write_gate

// ===== rtl/write_gate_pkg.sv
// Constants for the protected register write gate
package write_gate_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Peripheral frame windows (16-bit word addresses)
    // ------------------------------------------------------------------
    localparam logic [21:0] FRAME1_LO = 22'h006400;
    localparam logic [21:0] FRAME1_HI = 22'h006fff;
    localparam logic [21:0] FRAME2_LO = 22'h007000;
    localparam logic [21:0] FRAME2_HI = 22'h007fff;

    // ------------------------------------------------------------------
    // Fully protected ranges, inclusive
    // ------------------------------------------------------------------
    localparam int NUM_PROT = 7;
    localparam logic [21:0] PROT_LO [NUM_PROT] = '{
        22'h000880,  // Emulation configuration
        22'h000a80,  // Flash control
        22'h000ae0,  // Security module
        22'h000d00,  // Interrupt vector table
        22'h007010,  // System control
        22'h006f80,  // Pin-multiplexing control
        22'h006fe0   // Pin interrupt and wakeup select
    };
    localparam logic [21:0] PROT_HI [NUM_PROT] = '{
        22'h000984,
        22'h000adf,
        22'h000aef,
        22'h000dff,
        22'h00702f,
        22'h006fbf,
        22'h006fff
    };

    // ------------------------------------------------------------------
    // Ranges where protection is decided per register or bit
    // ------------------------------------------------------------------
    localparam logic [21:0] CMP_LO = 22'h006400;
    localparam logic [21:0] CMP_HI = 22'h00643f;
    localparam logic [21:0] PWM_LO = 22'h006800;
    localparam logic [21:0] PWM_HI = 22'h0068ff;
    localparam int SUB_W = 8;  // Low address bits indexing a per-register mask

    // ------------------------------------------------------------------
    // Status register one layout and timing
    // ------------------------------------------------------------------
    localparam int          STAT1_UNLOCK_BIT = 6;
    localparam logic [15:0] STAT1_RESET      = 16'h0000;
    localparam int          FRAME1_STALL_CYC = 1;

endpackage

// ===== rtl/protect_decode.sv
// Address decoder: frame membership and protection mask for one access
`timescale 1ns/100ps
module protect_decode #(
    parameter logic [255:0] CMP_REG_MASK = {256{1'b1}},
    parameter logic [255:0] PWM_REG_MASK = {256{1'b1}},
    parameter logic [31:0]  CMP_BIT_MASK = 32'hffffffff,
    parameter logic [31:0]  PWM_BIT_MASK = 32'hffffffff
) (
    input  wire logic [21:0] addr,
    output logic             in_frame1,
    output logic             in_frame2,
    output logic             prot_any,
    output logic [31:0]      prot_bits
);

    logic [6:0]  hit;
    logic        in_cmp;
    logic        in_pwm;
    logic [7:0]  sub;

    // ------------------------------------------------------------------
    // Whole-range protection, one comparator per range
    // ------------------------------------------------------------------
    // protected groups
    for (genvar i = 0; i < write_gate_pkg::NUM_PROT; i++) begin : g_rng
        assign hit[i] = (addr >= write_gate_pkg::PROT_LO[i]) &&
                        (addr <= write_gate_pkg::PROT_HI[i]);
    end

    assign in_frame1 = (addr >= write_gate_pkg::FRAME1_LO) && (addr <= write_gate_pkg::FRAME1_HI);
    assign in_frame2 = (addr >= write_gate_pkg::FRAME2_LO) && (addr <= write_gate_pkg::FRAME2_HI);
    assign in_cmp    = (addr >= write_gate_pkg::CMP_LO) && (addr <= write_gate_pkg::CMP_HI);
    assign in_pwm    = (addr >= write_gate_pkg::PWM_LO) && (addr <= write_gate_pkg::PWM_HI);
    assign sub       = addr[write_gate_pkg::SUB_W-1:0];

    // Whole word in fully protected ranges, else per-register then per-bit mask, nothing otherwise
    always_comb begin
        prot_bits = 32'h00000000;
        if (|hit) begin
            prot_bits = 32'hffffffff;
        end else if (in_cmp && CMP_REG_MASK[sub]) begin
            prot_bits = CMP_BIT_MASK;
        end else if (in_pwm && PWM_REG_MASK[sub]) begin
            prot_bits = PWM_BIT_MASK;
        end
    end

    assign prot_any = |prot_bits;

endmodule // protect_decode

// ===== tb/write_gate_chk.sv
// Port-level checks for the protected register write gate
`timescale 1ns/100ps
module write_gate_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        unlock_instruction,
    input wire logic        protect_instruction,
    input wire logic        protect_instruction_alias,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_wide,
    input wire logic        req_debug,
    input wire logic [21:0] req_addr,
    input wire logic        req_ready,
    input wire logic        req_done,
    input wire logic [31:0] req_rdata,
    input wire logic        per_valid,
    input wire logic        per_write,
    input wire logic [31:0] per_rdata,
    input wire logic [15:0] core_status_register_one,
    input wire logic        write_unlock_flag
);
    logic take, f1, f2w, pr;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Decode of the request; only fully protected ranges count here
    always_comb begin
        f1 = req_addr >= write_gate_pkg::FRAME1_LO && req_addr <= write_gate_pkg::FRAME1_HI;
        // Ready low only refuses a frame-one write
        take = clk_en && req_valid && (req_ready || !(req_write && f1));
        f2w = req_wide && req_addr >= write_gate_pkg::FRAME2_LO && req_addr <= write_gate_pkg::FRAME2_HI;
        pr = 1'b0;
        for (int i = 0; i < write_gate_pkg::NUM_PROT; i++) begin
            if (req_addr >= write_gate_pkg::PROT_LO[i] && req_addr <= write_gate_pkg::PROT_HI[i]) begin
                pr = 1'b1;
            end
        end
    end
    property p_stall; take && req_write && f1 |=> !req_ready; endproperty
    a_stall: assert property (p_stall) else $error("no stall after frame one write");
    property p_unstall; clk_en && !req_ready |=> req_ready; endproperty
    a_unstall: assert property (p_unstall) else $error("stall longer than one cycle");
    property p_done; take |=> req_done; endproperty
    a_done: assert property (p_done) else $error("request not completed");
    property p_f2wide; take && f2w |=> !per_valid; endproperty
    a_f2wide: assert property (p_f2wide) else $error("wide frame two access forwarded");
    property p_drop; take && req_write && !req_debug && !write_unlock_flag && pr |=> !per_valid && req_done; endproperty
    a_drop: assert property (p_drop) else $error("locked core write not dropped");
    property p_pass; take && !f2w && (!req_write || req_debug) |=> per_valid; endproperty
    a_pass: assert property (p_pass) else $error("read or debug access blocked");
    property p_open; take && req_write && write_unlock_flag && !f2w |=> per_valid; endproperty
    a_open: assert property (p_open) else $error("unlocked write blocked");
    property p_stat; core_status_register_one[write_gate_pkg::STAT1_UNLOCK_BIT] == write_unlock_flag; endproperty
    a_stat: assert property (p_stat) else $error("status bit differs from flag");
    property p_clr; clk_en && (protect_instruction || protect_instruction_alias) |=> !write_unlock_flag; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_rd; clk_en && per_valid && !per_write |=> req_rdata == $past(per_rdata); endproperty
    a_rd: assert property (p_rd) else $error("read data not returned");
    c_stall: cover property (take && req_write && f1 ##1 !req_ready);
    c_drop: cover property (take && req_write && !req_debug && !write_unlock_flag && pr);
    c_f2wide: cover property (take && f2w);
endmodule // write_gate_chk
bind protected_register_write_gate write_gate_chk u_write_gate_chk (.*);

// ===== tb/periph_model.sv
// Peripheral side model answering reads with address-derived data
`timescale 1ns/100ps
module periph_model (
    input  wire logic        mclk,
    input  wire logic        per_valid,
    input  wire logic [21:0] per_addr,
    output logic      [31:0] per_rdata
);
    logic [15:0] noise = 16'h0000;
    // Changing pattern while idle so stale data never looks valid
    always_ff @(posedge mclk) begin
        noise <= noise + 16'h0001;
    end
    assign per_rdata = per_valid ? ({10'h000, per_addr} ^ 32'h5a5a0000) : {noise, ~noise};
endmodule // periph_model

// ===== tb/testbench.sv
// Self-checking bench for the protected register write gate
`timescale 1ns/100ps
module testbench;
    localparam logic [31:0] CBITS = 32'h0000ff00;
    localparam logic [31:0] PBITS = 32'hffff0000;
    logic mclk, rst, clk_en, unlock_instruction, protect_instruction, protect_instruction_alias;
    logic req_valid, req_write, req_wide, req_debug, req_ready, req_done, per_valid;
    logic per_write, per_wide, write_unlock_flag, flag;
    logic [21:0] req_addr, per_addr, a;
    logic [31:0] req_wdata, req_rdata, per_wdata, per_wmask, per_rdata;
    logic [15:0] core_status_register_one;
    int mismatches, comparisons, waits, r;
    always #12.5 mclk = ~mclk;
    protected_register_write_gate #(.CMP_BIT_MASK(CBITS), .PWM_BIT_MASK(PBITS))
        u_protected_register_write_gate (.*);
    periph_model u_periph_model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic inr(input logic [21:0] x, input logic [21:0] lo, input logic [21:0] hi);
        return x >= lo && x <= hi;
    endfunction
    function automatic logic full_prot(input logic [21:0] x);
        for (int i = 0; i < write_gate_pkg::NUM_PROT; i++) begin
            if (inr(x, write_gate_pkg::PROT_LO[i], write_gate_pkg::PROT_HI[i])) return 1'b1;
        end
        return 1'b0;
    endfunction
    // One access, a frame-one write held until ready; ends at the negedge after completion, a read one negedge later
    task automatic xfer(input logic w, input logic wd, input logic dbg, input logic [21:0] x);
        logic fwd, lock, f1w;
        logic [31:0] m, d;
        lock = w && !dbg && !flag;
        f1w = w && inr(x, write_gate_pkg::FRAME1_LO, write_gate_pkg::FRAME1_HI);
        fwd = !(wd && inr(x, write_gate_pkg::FRAME2_LO, write_gate_pkg::FRAME2_HI));
        fwd = fwd && !(lock && full_prot(x));
        m = wd ? 32'hffffffff : 32'h0000ffff;
        if (lock && inr(x, write_gate_pkg::CMP_LO, write_gate_pkg::CMP_HI)) m = m & ~CBITS;
        if (lock && inr(x, write_gate_pkg::PWM_LO, write_gate_pkg::PWM_HI)) m = m & ~PBITS;
        req_valid = 1'b1;
        req_write = w;
        req_wide = wd;
        req_debug = dbg;
        req_addr = x;
        req_wdata = $urandom;
        d = req_wdata;
        waits = 0;
        // Ready low only holds back a frame-one write; others are taken at once
        while (f1w && req_ready !== 1'b1 && waits < 8) begin
            @(negedge mclk);
            waits++;
        end
        chk(32'(waits < 8), 32'h1);
        @(negedge mclk);
        chk(32'(req_done), 32'h1);
        chk(32'(per_valid), 32'(fwd));
        if (fwd) chk({per_write, per_wide, 8'h00, per_addr}, {w, wd, 8'h00, x});
        if (fwd && w) chk(per_wdata, d);
        if (fwd && w) chk(per_wmask, m);
        if (!w) begin
            req_valid = 1'b0;
            @(negedge mclk);
            chk(req_rdata, fwd ? ({10'h000, x} ^ 32'h5a5a0000) : 32'h0);
        end
    endtask
    // Instruction strobes for one cycle, then flag and status compared
    task automatic instr(input logic en, input logic u, input logic p, input logic q);
        req_valid = 1'b0;
        clk_en = en;
        unlock_instruction = u;
        protect_instruction = p;
        protect_instruction_alias = q;
        if (en) flag = (p || q) ? 1'b0 : (u ? 1'b1 : flag);
        @(negedge mclk);
        clk_en = 1'b1;
        unlock_instruction = 1'b0;
        protect_instruction = 1'b0;
        protect_instruction_alias = 1'b0;
        chk(32'(write_unlock_flag), 32'(flag));
        chk(32'(core_status_register_one[write_gate_pkg::STAT1_UNLOCK_BIT]), 32'(flag));
    endtask
    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    initial begin
        {mclk, rst, clk_en} = 3'b011;
        {unlock_instruction, protect_instruction, protect_instruction_alias} = 3'b000;
        {req_valid, req_write, req_wide, req_debug, req_addr, req_wdata} = '0;
        {flag, mismatches, comparisons} = '0;
        void'($urandom(16));
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        chk({15'h0, write_unlock_flag, core_status_register_one}, 32'h0);
        chk(32'(req_ready), 32'h1);
        $display("test reset done");
        for (int i = 0; i < write_gate_pkg::NUM_PROT; i++) begin
            xfer(1'b1, 1'b0, 1'b0, write_gate_pkg::PROT_LO[i]);
            xfer(1'b1, 1'b0, 1'b1, write_gate_pkg::PROT_HI[i]);
            xfer(1'b0, 1'b0, 1'b0, write_gate_pkg::PROT_HI[i]);
        end
        $display("test locked access done");
        xfer(1'b1, 1'b0, 1'b0, 22'h006a00);
        xfer(1'b1, 1'b1, 1'b0, 22'h006a02);
        chk(waits, 1);
        xfer(1'b1, 1'b1, 1'b0, 22'h006402);
        xfer(1'b1, 1'b0, 1'b0, 22'h006810);
        xfer(1'b0, 1'b1, 1'b0, 22'h007040);
        xfer(1'b1, 1'b0, 1'b0, 22'h007040);
        $display("test frames done");
        instr(1'b1, 1'b1, 1'b0, 1'b0);
        xfer(1'b1, 1'b0, 1'b0, 22'h007012);
        xfer(1'b1, 1'b1, 1'b0, 22'h006402);
        instr(1'b0, 1'b0, 1'b1, 1'b0);
        instr(1'b1, 1'b0, 1'b0, 1'b1);
        instr(1'b1, 1'b1, 1'b1, 1'b0);
        $display("test unlock and protect done");
        for (int n = 0; n < 300; n++) begin
            r = $urandom_range(0, 9);
            a = r < 7 ? write_gate_pkg::PROT_LO[r] : (r == 7 ? 22'h006400 : 22'h006800);
            if (r == 9) a = 22'h007040;
            a = a + 22'($urandom_range(0, 15));
            req_wide = 1'($urandom);
            if (req_wide) a[0] = 1'b0;
            xfer(1'($urandom), req_wide, 1'($urandom), a);
            if ($urandom_range(0, 3) == 0) instr(1'($urandom), 1'($urandom), 1'($urandom), 1'b0);
        end
        instr(1'b1, 1'b0, 1'b0, 1'b0);
        $display("test random traffic done");
        final_report();
    end
endmodule // testbench
